// File: verif/pwm_bank_chk.sv
// Checker for pin sharing, periods, counters and readback of the pwm bank
`timescale 1ns/10ps
module pwm_bank_chk (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [7:0] port_line_zero,
  input wire [3:0] port_line_twenty_four,
  input wire [7:0] low_pins,
  input wire [3:0] wide_pins
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] low_en_reg;
  logic [3:0] wide_en_reg;
  logic [2:0] p, p_q, e;
  logic [8:0] gap [3];
  logic [1:0] armed [3];
  assign p = {wide_pins[0], low_pins[4], low_pins[0]};
  assign e = {wide_en_reg[0], low_en_reg[4], low_en_reg[0]};
  // Cycles between rises; a write rearms, two rises must pass first
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_en_reg <= 8'h00;
      wide_en_reg <= 4'h0;
      p_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        gap[i] <= 9'h000;
        armed[i] <= 2'h0;
      end
    end else begin
      if (reg_wr && reg_addr == 8'h10) low_en_reg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h11) wide_en_reg <= reg_wdata[3:0];
      p_q <= p;
      for (int i = 0; i < 3; i++) begin
        gap[i] <= (p[i] && !p_q[i]) ? 9'h001 : gap[i] + 9'h001;
        if (reg_wr) armed[i] <= 2'h0;
        else if (p[i] && !p_q[i] && armed[i] != 2'h2) armed[i] <= armed[i] + 2'h1;
      end
    end
  end
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence wr_rd(logic [7:0] a);
    reg_wr && reg_addr == a ##1 rd_at(a);
  endsequence
  a_low_port_pass: assert property ($past(nrst) |-> ((low_pins ^ $past(port_line_zero))
    & ~low_en_reg & ~$past(low_en_reg)) == 8'h00) else $error("low pin not port line");
  a_wide_port_pass: assert property ($past(nrst) |-> ((wide_pins ^ $past(port_line_twenty_four))
    & ~wide_en_reg & ~$past(wide_en_reg)) == 4'h0) else $error("wide pin not port line");
  a_seven_period: assert property ($rose(p[0]) && armed[0] == 2'h2 && e[0] |-> gap[0] == 9'd384)
    else $error("seven-bit period wrong");
  a_six_period: assert property ($rose(p[1]) && armed[1] == 2'h2 && e[1] |-> gap[1] == 9'd192)
    else $error("six-bit period wrong");
  a_eight_period: assert property ($rose(p[2]) && armed[2] == 2'h2 && e[2] |-> gap[2] == 9'd256)
    else $error("eight-bit period wrong");
  a_wide_count_step: assert property (rd_at(8'h15) ##1 rd_at(8'h15) |=>
    reg_rdata == $past(reg_rdata) + 8'h01) else $error("wide counter step wrong");
  a_slow_count_step: assert property (rd_at(8'h14) ##3 rd_at(8'h14) |=>
    reg_rdata == (($past(reg_rdata, 3) + 8'h01) & 8'h7f)) else $error("slow counter step wrong");
  a_six_count_step: assert property (rd_at(8'h13) ##3 rd_at(8'h13) |=>
    reg_rdata == (($past(reg_rdata, 3) + 8'h01) & 8'h3f)) else $error("six-bit counter step wrong");
  a_polarity_readback: assert property (wr_rd(8'h12) |=>
    reg_rdata == ($past(reg_wdata, 2) & 8'h07)) else $error("polarity readback wrong");
  a_latch_width_mask: assert property (wr_rd(8'h04) |=>
    reg_rdata == ($past(reg_wdata, 2) & 8'h3f)) else $error("six-bit latch not masked");
endmodule

// File: verif/pwm_rc_filter.sv
// Partner model: rc integrators that accumulate the high time of five pwm pins
`timescale 1ns/10ps
module pwm_rc_filter (
  input wire ref_clk,
  input wire clr,
  input wire [4:0] pin,
  output logic [15:0] level [5]
);
  // Charge grows one step for each clock a pin stands high
  always @(posedge ref_clk)
    for (int i = 0; i < 5; i++)
      level[i] <= clr ? 16'h0000 : level[i] + {15'h0000, pin[i]};
endmodule

// File: verif/testbench.sv
// Testbench for the multi-resolution pwm bank
`timescale 1ns/10ps
module testbench;
  logic ref_clk, nrst, reg_wr, reg_rd, rc_clr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, port_line_zero, low_pins, rd_seen;
  logic [3:0] port_line_twenty_four, wide_pins;
  logic [15:0] lvl [5];
  logic [7:0] zero_addr [6] = '{8'h10, 8'h11, 8'h12, 8'h00, 8'h0a, 8'h20};
  int err_total, checks_done, cycles;
  multi_resolution_pwm_bank multi_resolution_pwm_bank_inst (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_line_zero(port_line_zero),
    .port_line_twenty_four(port_line_twenty_four), .low_pins(low_pins), .wide_pins(wide_pins));
  pwm_rc_filter pwm_rc_filter_inst (.ref_clk(ref_clk), .clr(rc_clr),
    .pin({wide_pins[1:0], low_pins[4], low_pins[1:0]}), .level(lvl));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    rd_seen = reg_rdata;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    check(what, {8'h00, rd_seen}, {8'h00, exp});
  endtask
  // Integrate over 768 clocks, a whole number of periods of every group
  task automatic measure(input logic [15:0] exp [5]);
    rc_clr <= 1'b1;
    @(posedge ref_clk);
    rc_clr <= 1'b0;
    repeat (768) @(posedge ref_clk);
    @(negedge ref_clk);
    for (int i = 0; i < 5; i++)
      check("rc level", lvl[i], exp[i]);
    @(posedge ref_clk);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_total++;
      close_out;
    end
  end
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rc_clr = 1'b0;
    port_line_zero = 8'ha5;
    port_line_twenty_four = 4'h9;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    foreach (zero_addr[i]) rd_chk("reset value", zero_addr[i], 8'h00);
    check("low_pins", {8'h00, low_pins}, 16'h00a5);
    check("wide_pins", {12'h000, wide_pins}, 16'h0009);
    op(1'b1, 1'b0, 8'h04, 8'hff);
    rd_chk("six latch", 8'h04, 8'h3f);
    op(1'b1, 1'b0, 8'h00, 8'hff);
    rd_chk("seven latch", 8'h00, 8'h7f);
    op(1'b1, 1'b0, 8'h00, 8'h02);
    op(1'b1, 1'b0, 8'h0a, 8'h40);
    op(1'b1, 1'b0, 8'h10, 8'hff);
    op(1'b1, 1'b0, 8'h11, 8'h0f);
    op(1'b0, 1'b1, 8'h15, 8'h00);
    op(1'b0, 1'b1, 8'h15, 8'h00);
    op(1'b0, 1'b1, 8'h14, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    op(1'b0, 1'b1, 8'h14, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (400) @(posedge ref_clk);
    measure('{16'd12, 16'd0, 16'd756, 16'd576, 16'd768});
    op(1'b1, 1'b0, 8'h12, 8'hff);
    rd_chk("polarity", 8'h12, 8'h07);
    repeat (400) @(posedge ref_clk);
    measure('{16'd756, 16'd768, 16'd12, 16'd192, 16'd0});
    op(1'b0, 1'b1, 8'h16, 8'h00);
    op(1'b0, 1'b1, 8'h17, 8'h00);
    check("low raw", {8'h00, rd_seen & 8'hee}, 16'h00ee);
    op(1'b0, 1'b1, 8'h13, 8'h00);
    check("wide raw", {8'h00, rd_seen & 8'h0e}, 16'h0000);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    op(1'b0, 1'b1, 8'h13, 8'h00);
    port_line_zero <= 8'h3c;
    port_line_twenty_four <= 4'h6;
    op(1'b1, 1'b0, 8'h10, 8'h00);
    op(1'b1, 1'b0, 8'h11, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    check("low_pins", {8'h00, low_pins}, 16'h003c);
    check("wide_pins", {12'h000, wide_pins}, 16'h0006);
    close_out;
  end
endmodule
bind multi_resolution_pwm_bank pwm_bank_chk pwm_bank_chk_inst (.ref_clk(ref_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .port_line_zero(port_line_zero),
  .port_line_twenty_four(port_line_twenty_four), .low_pins(low_pins), .wide_pins(wide_pins));

// File: verilog/multi_resolution_pwm_bank.v
// Bank of 7-, 6- and 8-bit pwm channels with register port and pin sharing
//
// Operation
// - Channels 0-3 have 7-bit, 4-7 have 6-bit and 10-13 have 8-bit resolution, each a pwm.
// - Channels 0-7 share pins with port lines 0-7, chosen per pin by the first enable register.
// - One polarity bit serves all 7-bit channels and another all 6-bit channels.
// - Slow channels step at a third of the clock, width three clocks per latch count.
// - The 6-bit period is 192 clocks and the 7-bit period is 384 clocks.
// - Channels 10-13 share pins with port lines 24-27, chosen by the second enable register.
// - One polarity bit in the second control register serves all 8-bit channels.
// - Wide channels step at the clock rate, width one clock per latch count.
// - The 8-bit period is 256 clocks.
// - A zero latch drives an 8-bit output high and a 6- or 7-bit output low.
`timescale 1ns/10ps
`include "pwm_bank_consts.vh"
module multi_resolution_pwm_bank #(
  parameter SEVEN_W = 7,
  parameter SIX_W = 6,
  parameter EIGHT_W = 8
) (
  input wire ref_clk,
  input wire nrst,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`DATA_W-1:0] reg_rdata,
  input wire [7:0] port_line_zero,
  input wire [3:0] port_line_twenty_four,
  output wire [7:0] low_pins,
  output wire [3:0] wide_pins
);

  // Data latches
  reg [SEVEN_W-1:0] seven_latch_reg [0:3];
  reg [SIX_W-1:0] six_latch_reg [0:3];
  reg [EIGHT_W-1:0] eight_latch_reg [0:3];

  // Control registers
  reg [7:0] low_channel_enable_reg;
  reg [3:0] wide_channel_enable_reg;
  reg [2:0] second_control_reg;

  // Counters
  reg [1:0] prescale_reg;
  reg [1:0] prescale_next;
  reg [SIX_W-1:0] six_count_reg;
  reg [SIX_W-1:0] six_count_next;
  reg [SEVEN_W-1:0] seven_count_reg;
  reg [SEVEN_W-1:0] seven_count_next;
  reg [EIGHT_W-1:0] eight_count_reg;
  reg [EIGHT_W-1:0] eight_count_next;

  // Read path
  reg [`DATA_W-1:0] reg_rdata_next;

  wire slow_step;
  wire seven_period_start;
  wire six_period_start;
  wire eight_period_start;
  wire seven_bit_polarity;
  wire six_bit_polarity;
  wire eight_bit_polarity;
  wire [7:0] channel_pin_select;
  wire [3:0] wide_pin_select;
  wire [7:0] low_pwm;
  wire [3:0] wide_pwm;

  // Write decode
  wire wr_seven;
  wire wr_six;
  wire wr_eight;
  wire wr_low_enable;
  wire wr_wide_enable;
  wire wr_control;
  wire [1:0] seven_index;
  wire [1:0] six_index;
  wire [1:0] eight_index;

  assign wr_seven = reg_wr && (reg_addr <= `LATCH_CH3);
  assign wr_six = reg_wr && (reg_addr >= `LATCH_CH4) && (reg_addr <= `LATCH_CH7);
  assign wr_eight = reg_wr && (reg_addr >= `LATCH_CH10) && (reg_addr <= `LATCH_CH13);
  assign wr_low_enable = reg_wr && (reg_addr == `LOW_CHANNEL_ENABLE_ADDR);
  assign wr_wide_enable = reg_wr && (reg_addr == `WIDE_CHANNEL_ENABLE_ADDR);
  assign wr_control = reg_wr && (reg_addr == `SECOND_CONTROL_ADDR);

  // Latch index within each group of four
  assign seven_index = reg_addr[1:0];
  assign six_index = reg_addr[1:0];
  assign eight_index = reg_addr[1:0] - 2'h2;

  // Field extraction
  assign seven_bit_polarity = second_control_reg[`SEVEN_BIT_POLARITY_BIT];
  assign six_bit_polarity = second_control_reg[`SIX_BIT_POLARITY_BIT];
  assign eight_bit_polarity = second_control_reg[`EIGHT_BIT_POLARITY_BIT];
  assign channel_pin_select = low_channel_enable_reg;
  assign wide_pin_select = wide_channel_enable_reg;

  // Data latch writes; upper data bits beyond each width are dropped
  integer i;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < 4; i = i + 1) begin
        seven_latch_reg[i] <= {SEVEN_W{1'b0}};
        six_latch_reg[i] <= {SIX_W{1'b0}};
        eight_latch_reg[i] <= {EIGHT_W{1'b0}};
      end
    end else begin
      if (wr_seven) begin
        seven_latch_reg[seven_index] <= reg_wdata[SEVEN_W-1:0];
      end
      if (wr_six) begin
        six_latch_reg[six_index] <= reg_wdata[SIX_W-1:0];
      end
      if (wr_eight) begin
        eight_latch_reg[eight_index] <= reg_wdata[EIGHT_W-1:0];
      end
    end
  end

  // Control register writes
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_channel_enable_reg <= `LOW_CHANNEL_ENABLE_RESET;
      wide_channel_enable_reg <= `WIDE_CHANNEL_ENABLE_RESET;
      second_control_reg <= `SECOND_CONTROL_RESET;
    end else begin
      if (wr_low_enable) begin
        low_channel_enable_reg <= reg_wdata;
      end
      if (wr_wide_enable) begin
        wide_channel_enable_reg <= reg_wdata[3:0];
      end
      if (wr_control) begin
        second_control_reg <= reg_wdata[2:0];
      end
    end
  end

  // Prescaler: one step every three clocks for the slow channels
  always @* begin
    if (prescale_reg == `PRESCALE_LAST) begin
      prescale_next = 2'h0;
    end else begin
      prescale_next = prescale_reg + 2'h1;
    end
  end

  assign slow_step = (prescale_reg == `PRESCALE_LAST);

  // Slow counters wrap at 64 and 128 steps: 192 and 384 clocks
  always @* begin
    six_count_next = six_count_reg;
    seven_count_next = seven_count_reg;
    if (slow_step) begin
      six_count_next = six_count_reg + {{(SIX_W-1){1'b0}}, 1'b1};
      seven_count_next = seven_count_reg + {{(SEVEN_W-1){1'b0}}, 1'b1};
    end
  end

  // Wide counter steps every clock and wraps at 256
  always @* begin
    eight_count_next = eight_count_reg + {{(EIGHT_W-1){1'b0}}, 1'b1};
  end

  // Counter registers run free from reset
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prescale_reg <= 2'h0;
      six_count_reg <= {SIX_W{1'b0}};
      seven_count_reg <= {SEVEN_W{1'b0}};
      eight_count_reg <= {EIGHT_W{1'b0}};
    end else begin
      prescale_reg <= prescale_next;
      six_count_reg <= six_count_next;
      seven_count_reg <= seven_count_next;
      eight_count_reg <= eight_count_next;
    end
  end

  // First cycle of each period, where new latch values are taken
  assign six_period_start = (six_count_reg == {SIX_W{1'b0}}) && (prescale_reg == 2'h0);
  assign seven_period_start = (seven_count_reg == {SEVEN_W{1'b0}}) && (prescale_reg == 2'h0);
  assign eight_period_start = (eight_count_reg == {EIGHT_W{1'b0}});

  // Channels 0-3: 7-bit resolution
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : seven_ch
      pwm_channel #(
        .WIDTH(SEVEN_W),
        .ZERO_HIGH(0)
      ) u_chan (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .period_start(seven_period_start),
        .count(seven_count_reg),
        .latch_value(seven_latch_reg[g]),
        .polarity(seven_bit_polarity),
        .pin_select(channel_pin_select[g]),
        .port_value(port_line_zero[g]),
        .pwm_reg(low_pwm[g]),
        .pin_reg(low_pins[g])
      );
    end
  endgenerate

  // Channels 4-7: 6-bit resolution
  generate
    for (g = 0; g < 4; g = g + 1) begin : six_ch
      pwm_channel #(
        .WIDTH(SIX_W),
        .ZERO_HIGH(0)
      ) u_chan (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .period_start(six_period_start),
        .count(six_count_reg),
        .latch_value(six_latch_reg[g]),
        .polarity(six_bit_polarity),
        .pin_select(channel_pin_select[g+4]),
        .port_value(port_line_zero[g+4]),
        .pwm_reg(low_pwm[g+4]),
        .pin_reg(low_pins[g+4])
      );
    end
  endgenerate

  // Channels 10-13: 8-bit resolution, idle high with zero value
  generate
    for (g = 0; g < 4; g = g + 1) begin : eight_ch
      pwm_channel #(
        .WIDTH(EIGHT_W),
        .ZERO_HIGH(1)
      ) u_chan (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .period_start(eight_period_start),
        .count(eight_count_reg),
        .latch_value(eight_latch_reg[g]),
        .polarity(eight_bit_polarity),
        .pin_select(wide_pin_select[g]),
        .port_value(port_line_twenty_four[g]),
        .pwm_reg(wide_pwm[g]),
        .pin_reg(wide_pins[g])
      );
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always @* begin
    reg_rdata_next = `UNMAPPED_READ;
    case (reg_addr)
      // 7-bit latches, top bit reads zero
      `LATCH_CH0: begin
        reg_rdata_next = {1'b0, seven_latch_reg[0]};
      end
      `LATCH_CH1: begin
        reg_rdata_next = {1'b0, seven_latch_reg[1]};
      end
      `LATCH_CH2: begin
        reg_rdata_next = {1'b0, seven_latch_reg[2]};
      end
      `LATCH_CH3: begin
        reg_rdata_next = {1'b0, seven_latch_reg[3]};
      end

      // 6-bit latches, top two bits read zero
      `LATCH_CH4: begin
        reg_rdata_next = {2'h0, six_latch_reg[0]};
      end
      `LATCH_CH5: begin
        reg_rdata_next = {2'h0, six_latch_reg[1]};
      end
      `LATCH_CH6: begin
        reg_rdata_next = {2'h0, six_latch_reg[2]};
      end
      `LATCH_CH7: begin
        reg_rdata_next = {2'h0, six_latch_reg[3]};
      end

      // 8-bit latches
      `LATCH_CH10: begin
        reg_rdata_next = eight_latch_reg[0];
      end
      `LATCH_CH11: begin
        reg_rdata_next = eight_latch_reg[1];
      end
      `LATCH_CH12: begin
        reg_rdata_next = eight_latch_reg[2];
      end
      `LATCH_CH13: begin
        reg_rdata_next = eight_latch_reg[3];
      end

      // Enables and control
      `LOW_CHANNEL_ENABLE_ADDR: begin
        reg_rdata_next = low_channel_enable_reg;
      end
      `WIDE_CHANNEL_ENABLE_ADDR: begin
        reg_rdata_next = {4'h0, wide_channel_enable_reg};
      end
      `SECOND_CONTROL_ADDR: begin
        reg_rdata_next = {5'h00, second_control_reg};
      end

      // Free-running counters, read only
      `SIX_COUNT_ADDR: begin
        reg_rdata_next = {2'h0, six_count_reg};
      end
      `SEVEN_COUNT_ADDR: begin
        reg_rdata_next = {1'b0, seven_count_reg};
      end
      `EIGHT_COUNT_ADDR: begin
        reg_rdata_next = eight_count_reg;
      end

      // Raw modulator states, read only
      `LOW_PIN_STATE_ADDR: begin
        reg_rdata_next = low_pwm;
      end
      `WIDE_PIN_STATE_ADDR: begin
        reg_rdata_next = {4'h0, wide_pwm};
      end
      default: begin
        reg_rdata_next = `UNMAPPED_READ;
      end
    endcase
  end

  // Read data stand only in the cycle after the read strobe
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `UNMAPPED_READ;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_next;
    end else begin
      reg_rdata <= `UNMAPPED_READ;
    end
  end

endmodule

// File: verilog/pwm_bank_consts.vh
// Constants for the multi-resolution pwm bank: register indices, fields, resets, timing
`ifndef PWM_BANK_CONSTS_VH
`define PWM_BANK_CONSTS_VH

// Register bus widths
`define ADDR_W 8
`define DATA_W 8

// Channel data latch indices: channel n sits at index n
`define LATCH_CH0 8'h00
`define LATCH_CH1 8'h01
`define LATCH_CH2 8'h02
`define LATCH_CH3 8'h03
`define LATCH_CH4 8'h04
`define LATCH_CH5 8'h05
`define LATCH_CH6 8'h06
`define LATCH_CH7 8'h07
`define LATCH_CH10 8'h0a
`define LATCH_CH11 8'h0b
`define LATCH_CH12 8'h0c
`define LATCH_CH13 8'h0d

// Control and status registers
`define LOW_CHANNEL_ENABLE_ADDR 8'h10
`define WIDE_CHANNEL_ENABLE_ADDR 8'h11
`define SECOND_CONTROL_ADDR 8'h12
`define SIX_COUNT_ADDR 8'h13
`define SEVEN_COUNT_ADDR 8'h14
`define EIGHT_COUNT_ADDR 8'h15
`define LOW_PIN_STATE_ADDR 8'h16
`define WIDE_PIN_STATE_ADDR 8'h17

// Fields of the second control register
`define SEVEN_BIT_POLARITY_BIT 0
`define SIX_BIT_POLARITY_BIT 1
`define EIGHT_BIT_POLARITY_BIT 2
`define SECOND_CONTROL_MASK 8'h07

// Reset values
`define LATCH_RESET 8'h00
`define LOW_CHANNEL_ENABLE_RESET 8'h00
`define WIDE_CHANNEL_ENABLE_RESET 4'h0
`define SECOND_CONTROL_RESET 3'h0
`define UNMAPPED_READ 8'h00

// Timing: slow channels step once every three crystal periods
`define SLOW_PRESCALE 3
`define PRESCALE_LAST 2'h2
`define SIX_BIT_PERIOD 192
`define SEVEN_BIT_PERIOD 384
`define EIGHT_BIT_PERIOD 256

`endif

// File: verilog/pwm_channel.v
// One pwm channel: period-aligned value load, compare, polarity and pin select
`timescale 1ns/10ps
module pwm_channel #(
  parameter WIDTH = 7,
  parameter ZERO_HIGH = 0
) (
  input wire ref_clk,
  input wire nrst,
  input wire period_start,
  input wire [WIDTH-1:0] count,
  input wire [WIDTH-1:0] latch_value,
  input wire polarity,
  input wire pin_select,
  input wire port_value,
  output reg pwm_reg,
  output reg pin_reg
);

  reg [WIDTH-1:0] active_value_reg;
  wire [WIDTH-1:0] value_now;
  wire active;
  wire shaped;
  wire pwm_next;
  wire pin_next;

  // New latch contents take effect at the start of a period only
  assign value_now = period_start ? latch_value : active_value_reg;

  // Active while the free-running count is below the value
  assign active = (count < value_now);

  // Wide channels idle high with a zero value, slow ones idle low
  assign shaped = (ZERO_HIGH != 0) ? ~active : active;

  assign pwm_next = shaped ^ polarity;

  // Pin carries the modulated output or the port line
  assign pin_next = pin_select ? pwm_next : port_value;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      active_value_reg <= {WIDTH{1'b0}};
      pwm_reg <= 1'b0;
      pin_reg <= 1'b0;
    end else begin
      active_value_reg <= value_now;
      pwm_reg <= pwm_next;
      pin_reg <= pin_next;
    end
  end

endmodule
